// >>> bench/host_port_model.sv
// Host model that drives the register port one byte per access.
`timescale 1ns/1ns
module host_port_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_write,
  output logic            reg_read,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // Released lines carry the inverse of the last value, so a device that
  // samples outside the strobe cycle sees wrong data rather than stale data.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = w;
    reg_read = !w;
    @(negedge clk);
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    d = reg_rdata;
  endtask : rd
endmodule : host_port_model

// >>> bench/motion_event_checker.sv
// Port assertions for the motion-event register bank.
`timescale 1ns/1ns
module motion_event_checker (
  input wire logic                      clk,
  input wire logic                      rstn,
  input wire logic [7:0]                reg_addr,
  input wire logic                      reg_write,
  input wire logic                      reg_read,
  input wire logic [7:0]                reg_wdata,
  input wire logic [7:0]                reg_rdata,
  input wire logic                      reg_hit,
  input wire motion_event_pkg::events_s events,
  input wire logic                      wake_cond,
  input wire motion_event_pkg::config_s cfg,
  input wire logic                      wake_timed
);
  localparam logic [4:0] THR [8] = '{5'h05, 5'h07, 5'h08, 5'h0a,
                                     5'h0b, 5'h0d, 5'h0f, 5'h10};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_hit_decode: assert property (
    reg_hit == (reg_addr >= 8'h34 && reg_addr <= 8'h38))
    else $error("hit flag disagrees with address");
  a_wr_threshold: assert property (reg_write && reg_addr == 8'h34 |=>
    {cfg.double_tap_en, cfg.inactivity_en, cfg.wake_threshold}
      == $past(reg_wdata)) else $error("threshold write not decoded");
  a_wr_duration: assert property (reg_write && reg_addr == 8'h35 |=>
    {cfg.fall_time[5], cfg.wake_time, cfg.stationary_en,
     cfg.inactivity_time} == $past(reg_wdata))
    else $error("duration write not decoded");
  a_wr_freefall: assert property (reg_write && reg_addr == 8'h36 |=>
    {cfg.fall_time[4:0], cfg.fall_threshold_lsb}
      == {$past(reg_wdata[7:3]), THR[$past(reg_wdata[2:0])]})
    else $error("free-fall write not decoded");
  a_mirror_read: assert property (reg_read && reg_addr == 8'h37 |=>
    reg_rdata == $past(events[11:4])) else $error("mirror word wrong");
  a_source_read: assert property (reg_read && reg_addr == 8'h38 |=>
    reg_rdata == {2'h0, $past(events.fall), $past(events.inactive),
                  $past(events[3:0])}) else $error("wake source wrong");
  a_unmapped_zero: assert property (reg_read && !reg_hit |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_wake_immediate: assert property (
    $rose(wake_cond) && cfg.wake_time == 2'h0 |-> wake_timed)
    else $error("zero wake time not immediate");
endmodule : motion_event_checker

bind motion_event_config_status motion_event_checker u_motion_event_checker (
  .clk, .rstn, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
  .reg_hit, .events, .wake_cond, .cfg, .wake_timed);

// >>> bench/motion_event_config_status_bench.sv
// Self-checking bench of the motion-event register bank.
`timescale 1ns/1ns
module motion_event_config_status_bench;
  logic                      clk, rstn, reg_write, reg_read, reg_hit;
  logic                      odr_tick;
  logic [7:0]                reg_addr, reg_wdata, reg_rdata, rd;
  logic [2:0]                cond, timed;
  logic [15:0]               n;
  int                        mismatches, check_count;
  motion_event_pkg::events_s events;
  motion_event_pkg::config_s cfg;
  logic [4:0]                thr [8] = '{5'h05, 5'h07, 5'h08, 5'h0a,
                                         5'h0b, 5'h0d, 5'h0f, 5'h10};
  motion_event_config_status u_motion_event_config_status (
    .clk, .rstn, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
    .reg_hit, .odr_tick, .events, .wake_cond(cond[0]),
    .still_cond(cond[1]), .low_g_cond(cond[2]), .cfg,
    .wake_timed(timed[0]), .inactivity_timed(timed[1]),
    .fall_timed(timed[2]));
  host_port_model u_host_port_model (
    .clk, .reg_rdata, .reg_addr, .reg_write, .reg_read, .reg_wdata);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_host_port_model.rd(a, rd);
    chk(rd, exp);
  endtask : rdchk
  // The data-period tick runs every cycle until the last free-fall check, so a count equals clock edges.
  task automatic measure(input int i, input logic [15:0] exp);
    cond[i] = 1'b1;
    n = 16'h0000;
    #1;
    while (timed[i] !== 1'b1 && n < 16'h2000) begin
      @(negedge clk);
      n++;
    end
    chk(n, exp);
    cond = 3'h0;
    @(negedge clk);
  endtask : measure
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #600000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'b0;
    odr_tick = 1'b1;
    cond = 3'h0;
    events = 12'h000;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    chk(cfg.fall_threshold_lsb, 16'h0005);
    chk({cfg.double_tap_en, cfg.stationary_en}, 16'h0000);
    measure(1, 16'h2000);
    rdchk(8'h34, 8'h00);
    rdchk(8'h35, 8'h00);
    rdchk(8'h36, 8'h00);
    u_host_port_model.wr(8'h34, 8'hc5);
    rdchk(8'h34, 8'hc5);
    chk({cfg.double_tap_en, cfg.inactivity_en}, 16'h0003);
    chk(cfg.wake_threshold, 16'h0005);
    u_host_port_model.wr(8'h35, 8'hb3);
    rdchk(8'h35, 8'hb3);
    chk({cfg.wake_time, cfg.stationary_en, cfg.inactivity_time},
        16'h0033);
    for (int i = 0; i < 8; i++) begin
      u_host_port_model.wr(8'h36, {i[4:0], i[2:0]});
      chk(cfg.fall_threshold_lsb, thr[i]);
      chk(cfg.fall_time, {1'b1, i[4:0]});
    end
    rdchk(8'h40, 8'h00);
    for (int k = 0; k < 2; k++) begin
      events = k ? 12'h5a3 : 12'ha5c;
      rdchk(8'h37, events[11:4]);
      rdchk(8'h38, {2'h0, events.fall, events.inactive,
                    events[3:0]});
    end
    u_host_port_model.wr(8'h35, 8'h40);
    u_host_port_model.wr(8'h36, 8'h18);
    measure(0, 16'h0002);
    measure(1, 16'h0010);
    measure(2, 16'h0003);
    u_host_port_model.wr(8'h35, 8'h01);
    measure(0, 16'h0000);
    measure(1, 16'h0200);
    // With no data-period tick the free-fall timer must not advance at all.
    odr_tick = 1'h0;
    measure(2, 16'h2000);
    tally_and_finish();
  end
endmodule : motion_event_config_status_bench

// >>> hdl/motion_event_cfg.svh
// Constants of the motion-event register bank: offsets, fields, resets, timing.
`ifndef MOTION_EVENT_CFG_SVH
`define MOTION_EVENT_CFG_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define ADDR_WAKE_THRESHOLD_CONTROL 8'h34
`define ADDR_WAKE_SLEEP_DURATION    8'h35
`define ADDR_FREEFALL_CONFIG        8'h36
`define ADDR_EVENT_STATUS_MIRROR    8'h37
`define ADDR_WAKE_SOURCE            8'h38

// ********************************************************************
// Field positions
// ********************************************************************
`define BIT_TAP_MODE        7
`define BIT_INACTIVITY_EN   6
`define BIT_FALL_TIME_MSB   7
`define BIT_STATIONARY      4
`define FALL_TIME_LO_POS    3

// ********************************************************************
// Reset values
// ********************************************************************
`define RST_WAKE_THRESHOLD_CONTROL 8'h00
`define RST_WAKE_SLEEP_DURATION    8'h00
`define RST_FREEFALL_CONFIG        8'h00

// ********************************************************************
// Timing in output data periods
// ********************************************************************
`define INACT_STEP_PERIODS  16'h0200
`define INACT_ZERO_PERIODS  16'h0010

`endif

// >>> hdl/motion_event_config_status.sv
// Configuration and status registers of the motion-event engine.
// Notes on behaviour
// - Tap mode bit: 0 single, 1 single+double.
// - Inactivity enable resets 0; 1 enables sleep.
// - Wake threshold six bits, 1/64 full scale.
// - Fall time: MSB at 35h, low five 36h.
// - Wake time two bits, one period per step.
// - Stationary bit resets 0, enables stationary detection.
// - Inactivity time step 512 periods; zero means 16.
// - Fall threshold codes decode to 5..16 LSB.
// - Overrun flag only when full and overwritten.
// - Temperature ready flag shows new temperature sample.
// - Inactive flag shown in both status registers.
// - Separate double-tap and single-tap flags.
// - Orientation change flag on position change.
// - Mirror status carries fall event flag.
// - Sample ready flag for new three-axis data.
// - Wake source carries wake event flag.
// - Per-axis wake flags for X, Y, Z.
// - Wake source also reports fall event.
`timescale 1ns/1ns
`include "motion_event_cfg.svh"
module motion_event_config_status (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_write,
  input  wire logic                    reg_read,
  input  wire logic [7:0]              reg_wdata,
  output logic [7:0]                   reg_rdata,
  output logic                         reg_hit,
  input  wire logic                    odr_tick,
  input  wire motion_event_pkg::events_s events,
  input  wire logic                    wake_cond,
  input  wire logic                    still_cond,
  input  wire logic                    low_g_cond,
  output motion_event_pkg::config_s    cfg,
  output logic                         wake_timed,
  output logic                         inactivity_timed,
  output logic                         fall_timed
);

  // ******************************************************************
  // Writable registers
  // ******************************************************************
  logic [7:0] wake_threshold_control_q;
  logic [7:0] wake_sleep_duration_q;
  logic [7:0] freefall_config_q;
  logic [7:0] reg_rdata_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_threshold_control_q <= `RST_WAKE_THRESHOLD_CONTROL;
    end else if (reg_write && reg_addr == `ADDR_WAKE_THRESHOLD_CONTROL) begin
      wake_threshold_control_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_sleep_duration_q <= `RST_WAKE_SLEEP_DURATION;
    end else if (reg_write && reg_addr == `ADDR_WAKE_SLEEP_DURATION) begin
      wake_sleep_duration_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      freefall_config_q <= `RST_FREEFALL_CONFIG;
    end else if (reg_write && reg_addr == `ADDR_FREEFALL_CONFIG) begin
      freefall_config_q <= reg_wdata;
    end
  end

  // ******************************************************************
  // Field decode
  // ******************************************************************
  logic [4:0] fall_lsb;

  always_comb begin
    unique case (freefall_config_q[2:0])
      3'h0: fall_lsb = 5'h05;
      3'h1: fall_lsb = 5'h07;
      3'h2: fall_lsb = 5'h08;
      3'h3: fall_lsb = 5'h0a;
      3'h4: fall_lsb = 5'h0b;
      3'h5: fall_lsb = 5'h0d;
      3'h6: fall_lsb = 5'h0f;
      3'h7: fall_lsb = 5'h10;
    endcase
  end

  always_comb begin
    cfg.double_tap_en  = wake_threshold_control_q[`BIT_TAP_MODE];
    cfg.inactivity_en  = wake_threshold_control_q[`BIT_INACTIVITY_EN];
    cfg.stationary_en  = wake_sleep_duration_q[`BIT_STATIONARY];
    cfg.wake_threshold = wake_threshold_control_q[5:0];
    cfg.wake_time      = wake_sleep_duration_q[6:5];
    cfg.fall_time      = {wake_sleep_duration_q[`BIT_FALL_TIME_MSB],
                          freefall_config_q[7:`FALL_TIME_LO_POS]};
    cfg.fall_threshold_lsb = fall_lsb;
    cfg.inactivity_time    = wake_sleep_duration_q[3:0];
  end

  // ******************************************************************
  // Duration timers
  // ******************************************************************
  // Each timer restarts whenever its condition drops, so a condition
  // must hold for the whole programmed number of data periods.
  logic [15:0] inact_target;

  always_comb begin
    if (cfg.inactivity_time == 4'h0) begin
      inact_target = `INACT_ZERO_PERIODS;
    end else begin
      inact_target = 16'(cfg.inactivity_time * `INACT_STEP_PERIODS);
    end
  end

  period_counter #(.WIDTH(2)) wake_timer (
    .clk    (clk),
    .rstn   (rstn),
    .run    (wake_cond),
    .tick   (odr_tick),
    .target (cfg.wake_time),
    .done   (wake_timed)
  );

  period_counter #(.WIDTH(16)) inact_timer (
    .clk    (clk),
    .rstn   (rstn),
    .run    (still_cond && cfg.inactivity_en),
    .tick   (odr_tick),
    .target (inact_target),
    .done   (inactivity_timed)
  );

  period_counter #(.WIDTH(6)) fall_timer (
    .clk    (clk),
    .rstn   (rstn),
    .run    (low_g_cond),
    .tick   (odr_tick),
    .target (cfg.fall_time),
    .done   (fall_timed)
  );

  // ******************************************************************
  // Status images and read port
  // ******************************************************************
  // Both status words are built from the same event struct so shared
  // flags can never disagree. Writes to them are ignored.
  logic [7:0] mirror_word;
  logic [7:0] source_word;

  always_comb begin
    mirror_word = {events.fifo_overrun,
                   events.temp_ready,
                   events.inactive,
                   events.double_tap,
                   events.single_tap,
                   events.orientation,
                   events.fall,
                   events.sample_ready};
    source_word = {2'h0,
                   events.fall,
                   events.inactive,
                   events.wake,
                   events.x_wake,
                   events.y_wake,
                   events.z_wake};
  end

  always_comb begin
    unique case (reg_addr)
      `ADDR_WAKE_THRESHOLD_CONTROL,
      `ADDR_WAKE_SLEEP_DURATION,
      `ADDR_FREEFALL_CONFIG,
      `ADDR_EVENT_STATUS_MIRROR,
      `ADDR_WAKE_SOURCE: reg_hit = 1'h1;
      default:           reg_hit = 1'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        `ADDR_WAKE_THRESHOLD_CONTROL: reg_rdata_q <= wake_threshold_control_q;
        `ADDR_WAKE_SLEEP_DURATION:    reg_rdata_q <= wake_sleep_duration_q;
        `ADDR_FREEFALL_CONFIG:        reg_rdata_q <= freefall_config_q;
        `ADDR_EVENT_STATUS_MIRROR:    reg_rdata_q <= mirror_word;
        `ADDR_WAKE_SOURCE:            reg_rdata_q <= source_word;
        default:                      reg_rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = reg_rdata_q;

endmodule : motion_event_config_status

// >>> hdl/motion_event_pkg.sv
// Types shared by the motion-event register bank.
package motion_event_pkg;

  // Event inputs from the detection engine.
  typedef struct packed {
    logic fifo_overrun;
    logic temp_ready;
    logic inactive;
    logic double_tap;
    logic single_tap;
    logic orientation;
    logic fall;
    logic sample_ready;
    logic wake;
    logic x_wake;
    logic y_wake;
    logic z_wake;
  } events_s;

  // Decoded configuration handed to the detection engine.
  typedef struct packed {
    logic       double_tap_en;
    logic       inactivity_en;
    logic       stationary_en;
    logic [5:0] wake_threshold;
    logic [1:0] wake_time;
    logic [5:0] fall_time;
    logic [4:0] fall_threshold_lsb;
    logic [3:0] inactivity_time;
  } config_s;

endpackage : motion_event_pkg

// >>> hdl/period_counter.sv
// Counter of output data periods that flags when a programmed count is reached.
`timescale 1ns/1ns
module period_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] target,
  output logic                  done
);

  logic [WIDTH-1:0] count_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
    end else if (!run) begin
      count_q <= '0;
    end else if (tick && (count_q != target)) begin
      count_q <= count_q + WIDTH'(1);
    end
  end

  assign done = run && (count_q == target);

endmodule : period_counter
